/* design/hrtb_core.sv */
/*
 Terminal-side acknowledgement timing, bundling and feedback resource logic.
 Assumes all strobes come from same-clock framing logic; slot indices 0..9.
*/
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Uplink ctl indicator sets same-frame data rate
// - Circuit downlink header indicator sets following payload
// - Circuit uplink header indicator sets following payload
// - Ack is one, nack is zero
// - Ack bits follow resource unit order
// - Unused ack positions are invalid, ignored
// - Version one reply counts are 36
// - Version two counts from slots, subchannels, streams
// - Terminal acks two frames after reception
// - Terminal circuit ack after 7.5 ms
// - Bundling or multiplexing chosen by configuration
// - Association set lookup per config and slot
// - Bundling ANDs acks per codeword
// - Threshold band selects resource index formula
// - Smallest detected element gives m; else configured
// - Missed assignment without uplink data: silence in bundling mode
// - Multiplexing ANDs codewords per slot if M>1
// - Candidate resource computed per associated slot
// - One symbol on one selected candidate resource
// - Downlink reply slot lookup for uplink data
// - Rank one under diversity, optional layers otherwise
// - Extended_ctl_channel indicators first, then requests, slot order
module hrtb_core #(
  parameter int CC_CYC = hrtb_pkg::CC_DELAY_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        frame_tick,
  input  wire logic        ri_valid,
  input  wire logic [1:0]  ri_src,
  input  wire logic [3:0]  ri_val,
  input  wire logic        extended_ctl_channel_valid,
  input  wire logic [2:0]  extended_ctl_channel_slot,
  input  wire logic [63:0] extended_ctl_channel_field,
  input  wire logic        extended_ctl_channel_rx_valid,
  input  wire logic [35:0] extended_ctl_channel_crc_ok,
  input  wire logic [35:0] extended_ctl_channel_used,
  input  wire logic        cc_rx_valid,
  input  wire logic        cc_crc_ok,
  input  wire logic        det_valid,
  input  wire logic [3:0]  det_slot,
  input  wire logic        det_grant,
  input  wire logic        det_release,
  input  wire logic        det_two,
  input  wire logic [1:0]  det_ack,
  input  wire logic [15:0] det_cluster,
  input  wire logic        ul_slot_tick,
  input  wire logic [3:0]  ul_slot,
  input  wire logic        dl_missed,
  input  wire logic        ul_data_busy,
  input  wire logic        ul_tx_valid,
  input  wire logic        tx_div,
  input  wire logic [2:0]  layers,
  output logic [31:0]      rdata,
  output logic [3:0]       ul_xd_rate,
  output logic [3:0]       cc_dl_rate,
  output logic [3:0]       cc_ul_rate,
  output logic [3:0]       extended_ctl_channel_rate_ind,
  output logic [3:0]       extended_ctl_channel_rate_req,
  output logic             extended_ctl_channel_ack_valid,
  output logic [35:0]      extended_ctl_channel_ack_bits,
  output logic [35:0]      extended_ctl_channel_ack_mask,
  output logic             cc_ack_valid,
  output logic             cc_ack,
  output logic             fb_valid,
  output logic [1:0]       fb_bits,
  output logic             fb_two,
  output logic [15:0]      fb_res,
  output logic             hq_valid,
  output logic [3:0]       hq_slot,
  output logic             hq_wrap,
  output logic [2:0]       rank_report,
  output logic [15:0]      dl_reply_count,
  output logic [15:0]      ul_reply_count
);
  import hrtb_pkg::*;

  hrtb_st_t r;
  hrtb_st_t n;

  // Returns {M, k0, k1, k2, k3}; unused k are zero
  function automatic logic [18:0] ktab(input logic [1:0] c, input logic [3:0] s);
    logic [18:0] t;
    t = '0;
    case (c)
      2'h0: begin
        if (s == 4'h2 || s == 4'h7) t = {3'h1, 4'h6, 12'h000};
        if (s == 4'h4 || s == 4'h9) t = {3'h1, 4'h4, 12'h000};
      end
      2'h1: begin
        if (s == 4'h2 || s == 4'h7) t = {3'h2, 4'h7, 4'h6, 8'h00};
        if (s == 4'h3 || s == 4'h8) t = {3'h1, 4'h4, 12'h000};
      end
      2'h2: begin
        if (s == 4'h2 || s == 4'h7) t = {3'h4, 4'h8, 4'h7, 4'h4, 4'h6};
        else if (s != 4'h0 && s != 4'h3 && s < 4'ha) t = {3'h1, 4'h1, 12'h000};
      end
      default: begin
        if (s == 4'h2 || s == 4'h3 || s == 4'h7 || s == 4'h8) t = {3'h1, 4'h7, 12'h000};
        if (s == 4'h4) t = {3'h1, 4'h5, 12'h000};
      end
    endcase
    return t;
  endfunction

  // Zero means no reply expected for that uplink slot
  function automatic logic [3:0] khich(input logic [1:0] c, input logic [3:0] s);
    case ({c, s})
      6'h02, 6'h07, 6'h12, 6'h17, 6'h32, 6'h37: khich = 4'h4;
      6'h03, 6'h08, 6'h38:                      khich = 4'h7;
      6'h04, 6'h09, 6'h13, 6'h18, 6'h22, 6'h27,
      6'h33, 6'h34:                             khich = 4'h6;
      default:                                  khich = 4'h0;
    endcase
  endfunction

  function automatic int thr(input int p, input int ru, input int sc);
    int v;
    v = ru * (sc * p - THR_SUB);
    return (v < 0) ? 0 : v / THR_DIV;
  endfunction

  always_comb begin
    logic [18:0] kt;
    int          th [5];
    int          m;
    int          k;
    int          idx;
    int          p;
    int          best_k;
    int          best_i;
    int          sel;
    int          res [4];
    int          nsl;
    logic        any;
    logic        two;
    logic        b0;
    logic        b1;
    logic [3:0]  sp;
    logic [3:0]  vld;
    hrtb_ent_t   e;
    logic [63:0] sh;
    kt = '0;
    m = 0;
    k = 0;
    idx = 0;
    p = 0;
    best_k = 16;
    best_i = 0;
    sel = 0;
    nsl = 0;
    any = 1'b0;
    two = 1'b0;
    b0 = 1'b1;
    b1 = 1'b1;
    sp = '0;
    vld = '0;
    e = '0;
    sh = '0;
    for (int j = 0; j < 5; j++) begin
      th[j] = thr(j, int'(r.geom[6:0]), int'(r.geom[15:8]));
    end
    for (int j = 0; j < 4; j++) begin
      res[j] = 0;
    end
    n = r;
    n.rdata = '0;
    n.e_av = 1'b0;
    n.cc_av = 1'b0;
    n.fb_valid = 1'b0;
    n.hq_valid = 1'b0;

    if (wr) begin
      case (addr)
        A_CTRL: begin
          n.mode = hrtb_mode_t'(wdata[0]);
          n.cfg = wdata[2:1];
          n.v2 = wdata[3];
        end
        A_OFS:   n.ofs = wdata[15:0];
        A_FALL:  n.fall = wdata[15:0];
        A_GEOM:  n.geom = wdata;
        A_STRM:  n.strm = wdata[7:0];
        default: n.v2 = r.v2;
      endcase
    end
    if (rd) begin
      for (int j = 0; j < NSLOT; j++) begin
        sh[j] = r.hist[j].valid;
      end
      case (addr)
        A_CTRL:  n.rdata = {28'h0, r.v2, r.cfg, r.mode};
        A_OFS:   n.rdata = {16'h0, r.ofs};
        A_FALL:  n.rdata = {16'h0, r.fall};
        A_GEOM:  n.rdata = r.geom;
        A_STRM:  n.rdata = {24'h0, r.strm};
        A_STAT:  n.rdata = {22'h0, sh[9:0]};
        A_CNT:   n.rdata = {r.ul_cnt, r.dl_cnt};
        default: n.rdata = '0;
      endcase
      sh = '0;
    end

    // Indicators hold until the next one from the same source arrives
    if (ri_valid) begin
      case (ri_src)
        2'h0:    n.ul_xd_rate = ri_val;
        2'h1:    n.cc_dl_rate = ri_val;
        2'h2:    n.cc_ul_rate = ri_val;
        default: n.ul_xd_rate = r.ul_xd_rate;
      endcase
    end
    // Field holds up to eight slots; larger frames are not covered
    if (extended_ctl_channel_valid && extended_ctl_channel_slot < r.geom[23:20]) begin
      sh = extended_ctl_channel_field >> (4 * (int'(r.geom[23:20]) - 1 - int'(extended_ctl_channel_slot)));
      n.e_req = sh[3:0];
      sh = extended_ctl_channel_field >> (4 * (2 * int'(r.geom[23:20]) - 1 - int'(extended_ctl_channel_slot)));
      n.e_ind = sh[3:0];
    end

    // Reception frame is captured, staged one frame, sent in the next
    if (extended_ctl_channel_rx_valid) begin
      n.cap_ok = extended_ctl_channel_crc_ok;
      n.cap_used = extended_ctl_channel_used;
    end
    if (frame_tick) begin
      n.st_ok = n.cap_ok;
      n.st_used = n.cap_used;
      n.cap_ok = '0;
      n.cap_used = '0;
      n.e_ack = r.st_ok & r.st_used;
      n.e_mask = r.st_used;
      n.e_av = |r.st_used;
    end

    // Two slots in flight cover a 7.5 ms delay over 5 ms frames
    for (int g = 0; g < 2; g++) begin
      if (r.ccv[g]) begin
        if (r.ccc[g] == 18'h0) begin
          n.ccv[g] = 1'b0;
          n.cc_av = 1'b1;
          n.cc_ack = r.cca[g];
        end else begin
          n.ccc[g] = r.ccc[g] - 18'h1;
        end
      end
    end
    if (cc_rx_valid) begin
      k = n.ccv[0] ? 1 : 0;
      n.ccv[k] = 1'b1;
      n.cca[k] = cc_crc_ok;
      n.ccc[k] = 18'(CC_CYC - 1);
    end
    k = 0;

    if (ul_slot_tick) begin
      kt = ktab(r.cfg, ul_slot);
      m = int'(kt[18:16]);
      for (int i = 0; i < 4; i++) begin
        if (i < m) begin
          k = int'(kt[15 - 4 * i -: 4]);
          idx = (int'(ul_slot) + NSLOT - k) % NSLOT;
          e = r.hist[idx];
          if (e.valid) begin
            vld[i] = 1'b1;
            any = 1'b1;
            two = two | e.two;
            b0 = b0 & e.ack[0];
            b1 = b1 & (e.two ? e.ack[1] : 1'b1);
            sp[i] = e.ack[0] & (e.two ? e.ack[1] : 1'b1);
            if (e.grant || e.rel) begin
              p = 3;
              for (int j = 3; j >= 0; j--) begin
                if (int'(e.cl) >= th[j] && int'(e.cl) < th[j + 1]) p = j;
              end
              res[i] = (m - i - 1) * th[p] + i * th[p + 1]
                       + int'(e.cl) + int'(r.ofs);
              if (k < best_k) begin
                best_k = k;
                best_i = i;
              end
            end else begin
              res[i] = int'(r.fall);
            end
          end
          n.hist[idx].valid = 1'b0;
        end
      end
      if (r.mode == HRTB_MUX && m > 1) begin
        // Channel selection: last acked slot picks the resource
        for (int i = 0; i < 4; i++) begin
          if (vld[i] && (sp[i] || !vld[sel])) sel = i;
        end
        n.fb_res = 16'(res[sel]);
        n.fb_bits = {sp[1], sp[0]};
        n.fb_two = 1'b1;
        n.fb_valid = any;
      end else begin
        n.fb_res = (best_k < 16) ? 16'(res[best_i]) : r.fall;
        n.fb_bits = {b1 & two, b0};
        n.fb_two = two;
        n.fb_valid = any && !(r.mode == HRTB_BUNDLE && dl_missed
                              && !ul_data_busy);
      end
    end

    // Writing after the release lets a new result win its slot
    if (det_valid && det_slot < 4'ha) begin
      n.hist[det_slot] = '{valid: 1'b1, grant: det_grant, rel: det_release,
                           two: det_two, ack: det_ack, cl: det_cluster};
    end

    if (ul_tx_valid && khich(r.cfg, ul_slot) != 4'h0) begin
      idx = int'(ul_slot) + int'(khich(r.cfg, ul_slot));
      n.hq_valid = 1'b1;
      n.hq_wrap = idx >= NSLOT;
      n.hq_slot = 4'(idx % NSLOT);
    end

    n.rank = (tx_div || layers == 3'h0) ? RANK_ONE : layers;
    nsl = (r.geom[19:16] > r.geom[23:20]) ? int'(r.geom[19:16]) : int'(r.geom[23:20]);
    n.dl_cnt = r.v2 ? 16'(nsl * ((int'(r.geom[31:24]) + 1) / 2) * int'(r.strm[3:0]))
                    : V1_COUNT;
    n.ul_cnt = r.v2 ? 16'(nsl * ((int'(r.geom[31:24]) + 1) / 2) * int'(r.strm[7:4]))
                    : V1_COUNT;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.mode <= hrtb_mode_t'(CTRL_RST[0]);
      r.cfg <= CTRL_RST[2:1];
      r.v2 <= CTRL_RST[3];
      r.ofs <= OFS_RST[15:0];
      r.fall <= FALL_RST[15:0];
      r.geom <= GEOM_RST;
      r.strm <= STRM_RST[7:0];
      r.rank <= RANK_ONE;
      r.dl_cnt <= V1_COUNT;
      r.ul_cnt <= V1_COUNT;
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign ul_xd_rate = r.ul_xd_rate;
  assign cc_dl_rate = r.cc_dl_rate;
  assign cc_ul_rate = r.cc_ul_rate;
  assign extended_ctl_channel_rate_ind = r.e_ind;
  assign extended_ctl_channel_rate_req = r.e_req;
  assign extended_ctl_channel_ack_valid = r.e_av;
  assign extended_ctl_channel_ack_bits = r.e_ack;
  assign extended_ctl_channel_ack_mask = r.e_mask;
  assign cc_ack_valid = r.cc_av;
  assign cc_ack = r.cc_ack;
  assign fb_valid = r.fb_valid;
  assign fb_bits = r.fb_bits;
  assign fb_two = r.fb_two;
  assign fb_res = r.fb_res;
  assign hq_valid = r.hq_valid;
  assign hq_slot = r.hq_slot;
  assign hq_wrap = r.hq_wrap;
  assign rank_report = r.rank;
  assign dl_reply_count = r.dl_cnt;
  assign ul_reply_count = r.ul_cnt;

  a_ack_masked: assert property (@(posedge clk) disable iff (!rst_n)
    extended_ctl_channel_ack_valid |-> (extended_ctl_channel_ack_bits & ~extended_ctl_channel_ack_mask) == 36'h0)
    else $error("ack bit set on unused position");
  a_ack_two_frames: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_tick && r.st_used != 36'h0)
    |=> extended_ctl_channel_ack_valid && extended_ctl_channel_ack_mask == $past(r.st_used))
    else $error("extended_ctl_channel ack not sent two frames later");
  a_v1_counts: assert property (@(posedge clk) disable iff (!rst_n)
    (!r.v2 && !(wr && addr == A_CTRL)) ##1 1'b1
    |=> dl_reply_count == 16'h0024 && ul_reply_count == 16'h0024)
    else $error("version one reply count not 36");
  a_rank_div: assert property (@(posedge clk) disable iff (!rst_n)
    tx_div |=> rank_report == 3'h1)
    else $error("rank not one under diversity");
  a_hq_reply: assert property (@(posedge clk) disable iff (!rst_n)
    (ul_tx_valid && r.cfg == 2'h2 && ul_slot == 4'h7)
    |=> hq_valid && hq_slot == 4'h3 && hq_wrap)
    else $error("reply slot wrong for uplink data");
  a_fb_silent: assert property (@(posedge clk) disable iff (!rst_n)
    (ul_slot_tick && r.mode == HRTB_BUNDLE && dl_missed && !ul_data_busy) |=> !fb_valid)
    else $error("ack sent after missed assignment");
  a_cc_single: assert property (@(posedge clk) disable iff (!rst_n)
    cc_ack_valid |-> $past(r.ccv != 2'h0))
    else $error("circuit ack without reception in flight");
  a_ri_apply: assert property (@(posedge clk) disable iff (!rst_n)
    (ri_valid && ri_src == 2'h0) |=> ul_xd_rate == $past(ri_val))
    else $error("uplink indicator not applied");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr > A_CNT) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

/* design/hrtb_pkg.sv */
/*
 Shared constants and types of the acknowledgement timing block.
 Assumes a single 20 MHz clock and same-clock framing strobes.
*/
package hrtb_pkg;
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_OFS  = 4'h1;
  localparam logic [3:0] A_FALL = 4'h2;
  localparam logic [3:0] A_GEOM = 4'h3;
  localparam logic [3:0] A_STRM = 4'h4;
  localparam logic [3:0] A_STAT = 4'h5;
  localparam logic [3:0] A_CNT  = 4'h6;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OFS_RST  = 32'h0000_0000;
  localparam logic [31:0] FALL_RST = 32'h0000_0000;
  localparam logic [31:0] GEOM_RST = 32'h0844_0c19;
  localparam logic [31:0] STRM_RST = 32'h0000_0011;

  localparam int          NSLOT     = 10;
  localparam int          RW        = 16;
  localparam int          EW        = 36;
  localparam logic [15:0] V1_COUNT  = 16'h0024;
  localparam int          THR_DIV   = 36;
  localparam int          THR_SUB   = 4;
  localparam logic [2:0]  RANK_ONE  = 3'h1;

  localparam int  CLK_NS        = 50;
  localparam real CC_DELAY_MS   = 7.5;
  localparam int  CC_DELAY_CYC  = int'(CC_DELAY_MS * 1.0e6 / CLK_NS);

  typedef enum logic {HRTB_BUNDLE = 1'b0, HRTB_MUX = 1'b1} hrtb_mode_t;

  typedef struct packed {
    logic        valid;
    logic        grant;
    logic        rel;
    logic        two;
    logic [1:0]  ack;
    logic [15:0] cl;
  } hrtb_ent_t;

  typedef struct packed {
    hrtb_mode_t            mode;
    logic [1:0]            cfg;
    logic                  v2;
    logic [15:0]           ofs;
    logic [15:0]           fall;
    logic [31:0]           geom;
    logic [7:0]            strm;
    hrtb_ent_t [9:0]       hist;
    logic [35:0]           cap_ok;
    logic [35:0]           cap_used;
    logic [35:0]           st_ok;
    logic [35:0]           st_used;
    logic [35:0]           e_ack;
    logic [35:0]           e_mask;
    logic                  e_av;
    logic [1:0]            ccv;
    logic [1:0]            cca;
    logic [1:0][17:0]      ccc;
    logic                  cc_av;
    logic                  cc_ack;
    logic                  fb_valid;
    logic [1:0]            fb_bits;
    logic                  fb_two;
    logic [15:0]           fb_res;
    logic                  hq_valid;
    logic [3:0]            hq_slot;
    logic                  hq_wrap;
    logic [3:0]            ul_xd_rate;
    logic [3:0]            cc_dl_rate;
    logic [3:0]            cc_ul_rate;
    logic [3:0]            e_ind;
    logic [3:0]            e_req;
    logic [2:0]            rank;
    logic [15:0]           dl_cnt;
    logic [15:0]           ul_cnt;
    logic [31:0]           rdata;
  } hrtb_st_t;
endpackage

/* test/hrtb_bs_model.sv */
/*
 Base station side of the air interface: frame boundary cadence.
 Assumes the device clock; frame length is shortened for simulation.
*/
`timescale 1ns/1ps
module hrtb_bs_model #(
  parameter int FRAME = 24,
  parameter int CC    = 20
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ul_rx,
  input  wire logic cc_rx,
  output logic      frame_tick,
  output logic      dl_ack,
  output logic      cc_dl_ack
);
  int cnt;
  int nfr;
  int ccnt;
  // Free running like the air frame, so ack delays span real boundaries
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 0;
      frame_tick <= 1'b0;
      nfr <= 0;
      ccnt <= 0;
      dl_ack <= 1'b0;
      cc_dl_ack <= 1'b0;
    end else begin
      cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
      frame_tick <= (cnt == FRAME - 1);
      // Downlink ack leaves with the third boundary after uplink data
      if (ul_rx) begin
        nfr <= 3;
      end else if (frame_tick && nfr != 0) begin
        nfr <= nfr - 1;
      end
      dl_ack <= frame_tick && nfr == 1;
      if (cc_rx) begin
        ccnt <= CC;
      end else if (ccnt != 0) begin
        ccnt <= ccnt - 1;
      end
      cc_dl_ack <= (ccnt == 1);
    end
  end
endmodule

/* test/tb_top.sv */
/*
 Self-checking bench for the acknowledgement timing core.
 Assumes the hand-over register map and timing; circuit delay shortened.
*/
`timescale 1ns/1ps
module tb_top;
  import hrtb_pkg::*;
  localparam int CC = 20;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ri_valid = 1'b0;
  logic        extended_ctl_channel_valid = 1'b0, extended_ctl_channel_rx_valid = 1'b0, cc_rx_valid = 1'b0, cc_crc_ok = 1'b0;
  logic        det_valid = 1'b0, det_grant = 1'b0, det_release = 1'b0, det_two = 1'b0;
  logic        ul_slot_tick = 1'b0, dl_missed = 1'b0, ul_data_busy = 1'b0;
  logic        ul_tx_valid = 1'b0, tx_div = 1'b1, lt;
  logic [3:0]  addr = 4'h0, ri_val = 4'h0, det_slot = 4'h0, ul_slot = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0]  ri_src = 2'h0, det_ack = 2'h0;
  logic [2:0]  extended_ctl_channel_slot = 3'h0, layers = 3'h0;
  logic [63:0] extended_ctl_channel_field = 64'h0;
  logic [35:0] extended_ctl_channel_crc_ok = 36'h0, extended_ctl_channel_used = 36'h0;
  logic [15:0] det_cluster = 16'h0;
  logic [31:0] rdata;
  logic [3:0]  ul_xd_rate, cc_dl_rate, cc_ul_rate, extended_ctl_channel_rate_ind, extended_ctl_channel_rate_req, hq_slot;
  logic [35:0] extended_ctl_channel_ack_bits, extended_ctl_channel_ack_mask;
  logic [15:0] fb_res, dl_reply_count, ul_reply_count;
  logic [1:0]  fb_bits;
  logic [2:0]  rank_report;
  logic        extended_ctl_channel_ack_valid, cc_ack_valid, cc_ack, fb_valid, fb_two, hq_valid, hq_wrap;
  logic        frame_tick, bs_dl_ack, bs_cc_ack;
  int          mismatches = 0, n_checks = 0, n, k;
  logic [11:0] e;
  // Reply delay per uplink slot, slot n in bits [4n+:4], zero = no reply
  logic [39:0] kt [4] = '{40'h67_4006_7400, 40'h06_4000_6400, 40'h00_6000_0600,
                          40'h07_4006_6400};

  hrtb_bs_model #(.CC(CC)) i_bs (.clk, .rst_n, .ul_rx(ul_tx_valid), .cc_rx(cc_rx_valid),
    .frame_tick, .dl_ack(bs_dl_ack), .cc_dl_ack(bs_cc_ack));
  hrtb_core #(.CC_CYC(CC)) i_dut (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .frame_tick, .ri_valid, .ri_src, .ri_val,
    .extended_ctl_channel_valid, .extended_ctl_channel_slot, .extended_ctl_channel_field, .extended_ctl_channel_rx_valid, .extended_ctl_channel_crc_ok, .extended_ctl_channel_used,
    .cc_rx_valid, .cc_crc_ok, .det_valid, .det_slot, .det_grant, .det_release, .det_two,
    .det_ack, .det_cluster, .ul_slot_tick, .ul_slot, .dl_missed, .ul_data_busy,
    .ul_tx_valid, .tx_div, .layers, .rdata, .ul_xd_rate, .cc_dl_rate, .cc_ul_rate,
    .extended_ctl_channel_rate_ind, .extended_ctl_channel_rate_req, .extended_ctl_channel_ack_valid, .extended_ctl_channel_ack_bits, .extended_ctl_channel_ack_mask,
    .cc_ack_valid, .cc_ack, .fb_valid, .fb_bits, .fb_two, .fb_res, .hq_valid, .hq_slot,
    .hq_wrap, .rank_report, .dl_reply_count, .ul_reply_count
  );

  always #25 clk = ~clk;

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, x);
  endtask

  task automatic det(input logic [3:0] s, input logic g, r, t, input logic [1:0] a,
                     input logic [15:0] c);
    @(posedge clk);
    {det_valid, det_slot, det_grant, det_release, det_two, det_ack, det_cluster}
      <= {1'b1, s, g, r, t, a, c};
    @(posedge clk);
    det_valid <= 1'b0;
  endtask

  // Expected word: {valid, two, bits, resource}
  task automatic fb(input logic [3:0] s, input logic ms, input logic [19:0] x);
    @(posedge clk);
    {ul_slot_tick, ul_slot, dl_missed} <= {1'b1, s, ms};
    @(posedge clk);
    ul_slot_tick <= 1'b0;
    #1 chk(fb_valid, x[19]);
    if (x[19]) chk({fb_two, fb_bits, fb_res}, x[18:0]);
  endtask

  initial begin
    #(20000 * 50);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({rank_report, dl_reply_count, ul_reply_count}, {RANK_ONE, V1_COUNT, V1_COUNT});
    rd_chk(A_GEOM, GEOM_RST);
    rd_chk(A_STRM, STRM_RST);
    wr_reg(A_STAT, 32'hffff_ffff);
    rd_chk(A_STAT, 32'h0);
    rd_chk(4'hf, 32'h0);
    // Source 3 is ignored, rates hold
    e = 12'h0;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      {ri_valid, ri_src, ri_val} <= {1'b1, 2'(s), 4'(s + 5)};
      @(posedge clk);
      ri_valid <= 1'b0;
      if (s < 3) e[11 - 4 * s -: 4] = 4'(s + 5);
      #1 chk({ul_xd_rate, cc_dl_rate, cc_ul_rate}, e);
    end
    // Second write names an absent slot and must be refused
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {extended_ctl_channel_valid, extended_ctl_channel_slot, extended_ctl_channel_field} <= {1'b1, i ? 3'h4 : 3'h2,
                                              i ? {64{1'b1}} : 64'h1234_5678};
      @(posedge clk);
      extended_ctl_channel_valid <= 1'b0;
      #1 chk({extended_ctl_channel_rate_ind, extended_ctl_channel_rate_req}, 8'h37);
    end
    do @(posedge clk); while (frame_tick !== 1'b1);
    {extended_ctl_channel_rx_valid, extended_ctl_channel_crc_ok, extended_ctl_channel_used} <= {1'b1, 36'h8_0000_0a5f, 36'hf_0000_0ffc};
    @(posedge clk);
    extended_ctl_channel_rx_valid <= 1'b0;
    n = 0;
    lt = 1'b0;
    for (int i = 0; i < 100 && extended_ctl_channel_ack_valid !== 1'b1; i++) begin
      lt = frame_tick;
      n += int'(frame_tick === 1'b1);
      @(posedge clk);
    end
    chk({lt, 8'(n)}, 9'h102);
    chk({extended_ctl_channel_ack_bits, extended_ctl_channel_ack_mask}, {36'h8_0000_0a5c, 36'hf_0000_0ffc});
    // Back to back circuit receptions: ack then nack
    @(posedge clk);
    {cc_rx_valid, cc_crc_ok} <= 2'b11;
    @(posedge clk);
    cc_crc_ok <= 1'b0;
    @(posedge clk);
    cc_rx_valid <= 1'b0;
    repeat (CC - 2) @(posedge clk);
    #1 chk(cc_ack_valid, 1'b0);
    @(posedge clk);
    #1 chk({cc_ack_valid, cc_ack}, 2'b11);
    @(posedge clk);
    #1 chk({cc_ack_valid, cc_ack}, 2'b10);
    @(posedge clk);
    layers <= 3'h3;
    repeat (2) @(posedge clk);
    #1 chk(rank_report, 3'h1);
    @(posedge clk);
    tx_div <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(rank_report, 3'h3);
    // Odd subchannel count exercises the ceiling, uplink slots the maximum
    wr_reg(A_GEOM, 32'h0753_0c19);
    wr_reg(A_STRM, 32'h23);
    wr_reg(A_CTRL, 32'h8);
    @(posedge clk);
    rd_chk(A_CNT, 32'h0028_003c);
    chk({ul_reply_count, dl_reply_count}, 32'h0028_003c);
    wr_reg(A_OFS, 32'h100);
    wr_reg(A_FALL, 32'h55);
    wr_reg(A_CTRL, 32'h2);
    @(posedge clk);
    #1 chk({ul_reply_count, dl_reply_count}, {V1_COUNT, V1_COUNT});
    det(4'h5, 1'b1, 1'b0, 1'b1, 2'b11, 16'd9);
    det(4'h6, 1'b1, 1'b0, 1'b1, 2'b01, 16'd14);
    rd_chk(A_STAT, 32'h60);
    fb(4'h2, 1'b0, 20'hd_0124);
    rd_chk(A_STAT, 32'h0);
    fb(4'h2, 1'b0, 20'h0);
    wr_reg(A_CTRL, 32'h0);
    det(4'h0, 1'b1, 1'b0, 1'b0, 2'b01, 16'd3);
    fb(4'h4, 1'b1, 20'h0);
    det(4'h1, 1'b1, 1'b0, 1'b1, 2'b10, 16'd22);
    @(posedge clk);
    ul_data_busy <= 1'b1;
    fb(4'h7, 1'b1, 20'he_0116);
    @(posedge clk);
    ul_data_busy <= 1'b0;
    det(4'h5, 1'b0, 1'b0, 1'b0, 2'b01, 16'd40);
    fb(4'h9, 1'b0, 20'h9_0055);
    wr_reg(A_CTRL, 32'h3);
    det(4'h5, 1'b1, 1'b0, 1'b1, 2'b11, 16'd3);
    det(4'h6, 1'b1, 1'b0, 1'b1, 2'b10, 16'd20);
    fb(4'h2, 1'b0, 20'hd_0103);
    for (int c = 0; c < 4; c++) begin
      wr_reg(A_CTRL, 32'(c << 1));
      for (int s = 0; s < 10; s++) begin
        k = int'(kt[c][4 * s +: 4]);
        @(posedge clk);
        {ul_tx_valid, ul_slot} <= {1'b1, 4'(s)};
        @(posedge clk);
        ul_tx_valid <= 1'b0;
        #1 chk(hq_valid, k != 0);
        if (k != 0) chk({hq_slot, hq_wrap}, {4'((s + k) % 10), s + k >= 10});
      end
    end
    test_done();
  end
endmodule
